// [design/slf_datapath.v]
// shift, subtract, swap, test, xor and vector-call datapath with the flag register
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "slf_regs.vh"

module slf_datapath #(
	parameter SP_W = 16
) (
	input  wire        mclk,
	input  wire        rst_b,
	// instruction issue
	input  wire        op_valid,
	input  wire        op_prefix,
	input  wire [7:0]  opcode,
	input  wire [7:0]  dst_data,
	input  wire [7:0]  src_data,
	input  wire        irq_entry,
	input  wire        illegal_trap,
	input  wire        interrupt_return,
	input  wire [15:0] cur_pc,
	// data memory for the stack and vectors
	output reg  [15:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	output reg         mem_we,
	output reg         mem_re,
	input  wire [7:0]  mem_rdata,
	// results
	output reg  [7:0]  result,
	output reg         result_we,
	output reg  [15:0] new_pc,
	output reg         pc_load,
	output wire        busy,
	output wire [3:0]  cond_flags,
	// register port
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata
);

////////////////////////////////////////////////////////////////////////////////
// sequencer states, one-hot
localparam [10:0] ST_IDLE = 11'h001;
localparam [10:0] ST_TV1  = 11'h002;
localparam [10:0] ST_TV2  = 11'h004;
localparam [10:0] ST_TV3  = 11'h008;
localparam [10:0] ST_TV4  = 11'h010;
localparam [10:0] ST_TV5  = 11'h020;
localparam [10:0] ST_TV6  = 11'h040;
localparam [10:0] ST_RI1  = 11'h080;
localparam [10:0] ST_RI2  = 11'h100;
localparam [10:0] ST_RI3  = 11'h200;
localparam [10:0] ST_RI4  = 11'h400;
// stack steps at the pointer's own width
localparam [SP_W-1:0] SP_ONE = {{(SP_W-1){1'b0}}, 1'b1};
localparam [SP_W-1:0] SP_TWO = {{(SP_W-2){1'b0}}, 2'b10};

reg [10:0]     state_reg;
reg [10:0]     state_next;
reg [5:0]      stat_reg;
reg [5:0]      stat_next;
reg [1:0]      user_reg;
reg [1:0]      user_next;
reg [SP_W-1:0] sp_reg;
reg [SP_W-1:0] sp_next;
reg [7:0]      vec_reg;
reg [7:0]      vec_next;
reg [15:0]     pcsave_reg;
reg [15:0]     pcsave_next;
reg [7:0]      tmp_reg;
reg [7:0]      tmp_next;

wire [7:0] flags_full;
wire       idle;
wire       is_trap_op;
wire       trap_start;

// flag byte as software and the stack see it
assign flags_full = {stat_reg, user_reg};
assign idle       = state_reg == ST_IDLE;
assign busy       = !idle;
assign is_trap_op = op_valid && !op_prefix && opcode == `SLF_OP_TRAP;
// any of the three trap sources runs the same push sequence
assign trap_start = idle && (is_trap_op || irq_entry || illegal_trap);

// only carry, zero, sign and overflow leave the block as conditions
assign cond_flags = {flags_full[`SLF_FB_CARRY], flags_full[`SLF_FB_ZERO],
	flags_full[`SLF_FB_SIGN], flags_full[`SLF_FB_OVF]};

////////////////////////////////////////////////////////////////////////////////
// alu: result and six status bits; stat index 5..0 = C Z S V D H
reg [7:0] alu_res;
reg       alu_wr;
reg       alu_hit;
reg [5:0] alu_stat;
reg [8:0] diff;
reg [4:0] hdiff;

always @* begin
	alu_res  = 8'h00;
	alu_wr   = 1'b0;
	alu_hit  = 1'b0;
	alu_stat = stat_reg; // unchanged unless an entry says otherwise
	diff     = {1'b0, dst_data} - {1'b0, src_data};
	hdiff    = {1'b0, dst_data[3:0]} - {1'b0, src_data[3:0]};
	if (op_valid && idle && op_prefix) begin
		if (opcode == `SLF_OP_LSHR_R || opcode == `SLF_OP_LSHR_IR) begin
			alu_res     = {1'b0, dst_data[7:1]};
			alu_wr      = 1'b1;
			alu_hit     = 1'b1;
			alu_stat[5] = dst_data[0];
			alu_stat[4] = alu_res == 8'h00;
			alu_stat[3] = 1'b0;
			alu_stat[2] = dst_data[7] ^ alu_res[7]; // sign change of the operand
		end
	end else if (op_valid && idle) begin
		if (opcode == `SLF_OP_ASHR_R || opcode == `SLF_OP_ASHR_IR) begin
			alu_res     = {dst_data[7], dst_data[7:1]};
			alu_wr      = 1'b1;
			alu_hit     = 1'b1;
			alu_stat[5] = dst_data[0];
			alu_stat[4] = alu_res == 8'h00;
			alu_stat[3] = alu_res[7];
			alu_stat[2] = 1'b0;
		end else if (opcode >= `SLF_OP_SUB_LO && opcode <= `SLF_OP_SUB_HI) begin
			alu_res     = diff[7:0];
			alu_wr      = 1'b1;
			alu_hit     = 1'b1;
			alu_stat[5] = diff[8];
			alu_stat[4] = diff[7:0] == 8'h00;
			alu_stat[3] = diff[7];
			alu_stat[2] = (dst_data[7] ^ src_data[7]) & (dst_data[7] ^ diff[7]);
			alu_stat[1] = 1'b1;
			alu_stat[0] = hdiff[4];
		end else if (opcode == `SLF_OP_SWAP_R || opcode == `SLF_OP_SWAP_IR) begin
			// carry and overflow undefined: left as they were
			alu_res     = {dst_data[3:0], dst_data[7:4]};
			alu_wr      = 1'b1;
			alu_hit     = 1'b1;
			alu_stat[4] = alu_res == 8'h00;
			alu_stat[3] = alu_res[7];
		end else if (opcode >= `SLF_OP_CTST_LO && opcode <= `SLF_OP_CTST_HI) begin
			alu_res     = ~dst_data & src_data;
			alu_hit     = 1'b1;
			alu_stat[4] = alu_res == 8'h00;
			alu_stat[3] = alu_res[7];
			alu_stat[2] = 1'b0;
		end else if (opcode >= `SLF_OP_ATST_LO && opcode <= `SLF_OP_ATST_HI) begin
			alu_res     = dst_data & src_data;
			alu_hit     = 1'b1;
			alu_stat[4] = alu_res == 8'h00;
			alu_stat[3] = alu_res[7];
			alu_stat[2] = 1'b0;
		end else if (opcode >= `SLF_OP_XOR_LO && opcode <= `SLF_OP_XOR_HI) begin
			alu_res     = dst_data ^ src_data;
			alu_wr      = 1'b1;
			alu_hit     = 1'b1;
			alu_stat[4] = alu_res == 8'h00;
			alu_stat[3] = alu_res[7];
			alu_stat[2] = 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer for vector call, trap, interrupt entry and interrupt return
always @* begin
	state_next  = state_reg;
	stat_next   = stat_reg;
	user_next   = user_reg;
	sp_next     = sp_reg;
	vec_next    = vec_reg;
	pcsave_next = pcsave_reg;
	tmp_next    = tmp_reg;
	// explicit write from software; arithmetic never touches the user bits
	if (reg_wr && reg_addr == `SLF_OFF_FLAGS) begin
		stat_next = reg_wdata[7:2];
		user_next = reg_wdata[1:0];
	end
	if (reg_wr && reg_addr == `SLF_OFF_SP_HI && idle)
		sp_next = {reg_wdata, sp_reg[7:0]};
	if (reg_wr && reg_addr == `SLF_OFF_SP_LO && idle)
		sp_next = {sp_reg[SP_W-1:8], reg_wdata};
	// an instruction result outranks a software write in the same cycle
	if (alu_hit)
		stat_next = alu_stat;
	case (state_reg)
	ST_IDLE: begin
		if (trap_start) begin
			vec_next    = src_data;
			pcsave_next = cur_pc;
			sp_next     = sp_reg - SP_TWO;
			state_next  = ST_TV1;
		end else if (interrupt_return) begin
			state_next = ST_RI1;
		end
	end
	ST_TV1: state_next = ST_TV2;
	ST_TV2: begin
		tmp_next   = mem_rdata; // vector high byte
		state_next = ST_TV3;
	end
	ST_TV3: state_next = ST_TV4;
	ST_TV4: begin
		sp_next    = sp_reg - SP_ONE;
		state_next = ST_TV5;
	end
	ST_TV5: state_next = ST_TV6;
	ST_TV6: state_next = ST_IDLE;
	ST_RI1: begin
		sp_next    = sp_reg + SP_ONE;
		state_next = ST_RI2;
	end
	ST_RI2: begin
		// flag byte popped back, user bits included
		stat_next  = mem_rdata[7:2];
		user_next  = mem_rdata[1:0];
		sp_next    = sp_reg + SP_ONE;
		state_next = ST_RI3;
	end
	ST_RI3: begin
		tmp_next   = mem_rdata;
		sp_next    = sp_reg + SP_ONE;
		state_next = ST_RI4;
	end
	ST_RI4: state_next = ST_IDLE;
	default: state_next = ST_IDLE;
	endcase
end

// state, flags and stack pointer; user bits sit outside the reset branch
always @(posedge mclk) begin
	if (!rst_b) begin
		state_reg  <= ST_IDLE;
		stat_reg   <= `SLF_RST_FLAGS6;
		sp_reg     <= `SLF_RST_SP;
		vec_reg    <= 8'h00;
		pcsave_reg <= 16'h0000;
		tmp_reg    <= 8'h00;
	end else begin
		state_reg  <= state_next;
		stat_reg   <= stat_next;
		sp_reg     <= sp_next;
		vec_reg    <= vec_next;
		pcsave_reg <= pcsave_next;
		tmp_reg    <= tmp_next;
	end
end

// no defined power-up value and untouched by reset
always @(posedge mclk) begin
	user_reg <= user_next;
end

////////////////////////////////////////////////////////////////////////////////
// memory strobes, registered; mem_we stays high through TV4-TV5 and mem_re through RI1-RI3, one access per cycle
always @(posedge mclk) begin
	if (!rst_b) begin
		mem_addr  <= 16'h0000;
		mem_wdata <= 8'h00;
		mem_we    <= 1'b0;
		mem_re    <= 1'b0;
	end else begin
		mem_we <= 1'b0;
		mem_re <= 1'b0;
		case (state_next)
		ST_TV1: begin
			mem_addr <= {8'h00, src_data}; // vector high byte
			mem_re   <= 1'b1;
		end
		ST_TV2: begin
			mem_addr  <= sp_reg[15:0];
			mem_wdata <= pcsave_reg[15:8];
			mem_we    <= 1'b1;
		end
		ST_TV3: begin
			mem_addr <= {8'h00, vec_reg + 8'h01};
			mem_re   <= 1'b1;
		end
		ST_TV4: begin
			mem_addr  <= sp_reg[15:0] + 16'h0001;
			mem_wdata <= pcsave_reg[7:0];
			mem_we    <= 1'b1;
		end
		ST_TV5: begin
			mem_addr  <= sp_next[15:0];
			mem_wdata <= flags_full;
			mem_we    <= 1'b1;
		end
		ST_RI1, ST_RI2, ST_RI3: begin
			mem_addr <= sp_next[15:0]; // flag byte, then pc high, then pc low
			mem_re   <= 1'b1;
		end
		default: begin
			mem_addr <= mem_addr;
		end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// results, new program counter and register read data
always @(posedge mclk) begin
	if (!rst_b) begin
		result    <= 8'h00;
		result_we <= 1'b0;
		new_pc    <= 16'h0000;
		pc_load   <= 1'b0;
		reg_rdata <= 8'h00;
	end else begin
		result_we <= alu_wr;
		pc_load   <= 1'b0;
		if (alu_hit)
			result <= alu_res;
		// vector low byte stands only in the cycle after its read: latch it there
		if (state_reg == ST_TV4)
			new_pc <= {tmp_reg, mem_rdata};
		if (state_reg == ST_TV5)
			pc_load <= 1'b1;
		if (state_reg == ST_RI4) begin
			new_pc  <= {tmp_reg, mem_rdata};
			pc_load <= 1'b1;
		end
		if (reg_rd) begin
			case (reg_addr)
			`SLF_OFF_FLAGS:  reg_rdata <= flags_full;
			`SLF_OFF_SP_HI:  reg_rdata <= sp_reg[15:8];
			`SLF_OFF_SP_LO:  reg_rdata <= sp_reg[7:0];
			`SLF_OFF_STATUS: reg_rdata <= {7'h00, busy};
			default:         reg_rdata <= 8'h00;
			endcase
		end
	end
end

endmodule

// [design/slf_regs.vh]
// register offsets, flag bit positions, opcodes and timing counts of the datapath
`ifndef SLF_REGS_VH
`define SLF_REGS_VH

// register port offsets
`define SLF_OFF_FLAGS      4'h0
`define SLF_OFF_SP_HI      4'h1
`define SLF_OFF_SP_LO      4'h2
`define SLF_OFF_STATUS     4'h3

// flag bit positions in the flag register
`define SLF_FB_CARRY       7
`define SLF_FB_ZERO        6
`define SLF_FB_SIGN        5
`define SLF_FB_OVF         4
`define SLF_FB_DEC         3
`define SLF_FB_HALF        2
`define SLF_FB_USER1       1
`define SLF_FB_USER2       0

// reset values
`define SLF_RST_FLAGS6     6'h00
`define SLF_RST_SP         16'h0000

// opcodes, first byte unless noted
`define SLF_OP_ASHR_R      8'hD0
`define SLF_OP_ASHR_IR     8'hD1
`define SLF_OP_PREFIX      8'h1F
`define SLF_OP_LSHR_R      8'hC0
`define SLF_OP_LSHR_IR     8'hC1
`define SLF_OP_SUB_LO      8'h22
`define SLF_OP_SUB_HI      8'h29
`define SLF_OP_SWAP_R      8'hF0
`define SLF_OP_SWAP_IR     8'hF1
`define SLF_OP_CTST_LO     8'h62
`define SLF_OP_CTST_HI     8'h69
`define SLF_OP_ATST_LO     8'h72
`define SLF_OP_ATST_HI     8'h79
`define SLF_OP_XOR_LO      8'hB2
`define SLF_OP_XOR_HI      8'hB9
`define SLF_OP_TRAP        8'hF2

// timing counts in clock cycles
`define SLF_TRAP_CYCLES    6
`define SLF_FETCH_TRAP     2
`define SLF_FETCH_SRL      3

`endif

// [tb/slf_datapath_properties.sv]
// port-level assertions on the datapath, bound into every slf_datapath
`timescale 1ns/1ps
module slf_props (
	input wire       mclk,
	input wire       rst_b,
	input wire       op_valid,
	input wire       op_prefix,
	input wire [7:0] opcode,
	input wire [7:0] dst_data,
	input wire [7:0] src_data,
	input wire       irq_entry,
	input wire       illegal_trap,
	input wire       interrupt_return,
	input wire       busy,
	input wire [7:0] result,
	input wire       result_we,
	input wire       pc_load,
	input wire [3:0] cond_flags,
	input wire [3:0] reg_addr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata
);
	reg [7:0] d_q, s_q;
	reg       c_q;
	// decode, only where the datapath accepts the issue
	wire np  = op_valid && !busy && !op_prefix;
	wire ash = np && opcode[7:1] == 7'h68;
	wire lsh = op_valid && !busy && op_prefix && opcode[7:1] == 7'h60;
	wire swp = np && opcode[7:1] == 7'h78;
	wire sub = np && opcode >= 8'h22 && opcode <= 8'h29;
	wire tst = np && opcode[7:5] == 3'h3 && opcode[3:0] > 4'h1 && opcode[3:0] < 4'hA;
	wire trp = !busy && (irq_entry || illegal_trap || np && opcode == 8'hF2);
	wire ret = !busy && interrupt_return && !trp;
	// operands and carry kept one cycle to judge the answer
	always @(posedge mclk) begin
		d_q <= dst_data;
		s_q <= src_data;
		c_q <= cond_flags[3];
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////
	a_arith_sign: assert property (ash |=> result == {d_q[7], d_q[7:1]}
		&& cond_flags[3] == d_q[0] && !cond_flags[0]) else $error("bad arith shift");
	a_logic_fill: assert property (lsh |=> result == {1'b0, d_q[7:1]}
		&& cond_flags[3] == d_q[0] && !cond_flags[1]) else $error("bad logic shift");
	a_sub_diff: assert property (sub |=> result_we && result == d_q - s_q
		&& cond_flags[3] == (d_q < s_q)) else $error("bad subtract");
	a_swap_nib: assert property (swp |=> result == {d_q[3:0], d_q[7:4]})
		else $error("bad swap");
	a_test_keep: assert property (tst |=> !result_we && !cond_flags[0]
		&& cond_flags[3] == c_q) else $error("bad test op");
	a_trap_len: assert property (trp |=> busy[*6] ##0 pc_load)
		else $error("bad trap length");
	a_ret_len: assert property (ret |=> busy ##4 pc_load)
		else $error("bad return length");
	a_cond_src: assert property (reg_rd && reg_addr == 4'h0 |=>
		reg_rdata[7:4] == $past(cond_flags)) else $error("bad cond flags");
	c_trap: cover property (trp);
	c_ret: cover property (ret);
	c_sub: cover property (sub ##1 result_we);
endmodule
bind slf_datapath slf_props i_slf_props (.mclk, .rst_b, .op_valid, .op_prefix, .opcode,
	.dst_data, .src_data, .irq_entry, .illegal_trap, .interrupt_return, .busy, .result,
	.result_we, .pc_load, .cond_flags, .reg_addr, .reg_rd, .reg_rdata);

// [tb/tb_top.sv]
// self-checking bench for the datapath ports
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	reg         mclk = 0, rst_b = 0, op_valid = 0, op_prefix = 0, irq_entry = 0;
	reg         illegal_trap = 0, interrupt_return = 0, reg_wr = 0, reg_rd = 0, p, ew;
	reg  [7:0]  opcode = 0, dst_data = 0, src_data = 0, mem_rdata = 0, reg_wdata = 0;
	reg  [7:0]  c, ef, er, mem [0:255];
	reg  [7:0]  dv [0:2] = '{8'h05, 8'h81, 8'h5A};
	reg  [7:0]  sv [0:2] = '{8'h07, 8'h7F, 8'h5A};
	reg  [15:0] cur_pc = 0, hi_ok = 16'h08C4;
	reg  [3:0]  reg_addr = 0;
	wire [15:0] mem_addr, new_pc;
	wire [7:0]  mem_wdata, result, reg_rdata;
	wire [3:0]  cond_flags;
	wire        mem_we, mem_re, result_we, pc_load, busy;
	integer     n_fail = 0, checks_done = 0, cyc = 0, i, j, k;

	slf_datapath i_slf_datapath (.mclk, .rst_b, .op_valid, .op_prefix, .opcode, .dst_data,
		.src_data, .irq_entry, .illegal_trap, .interrupt_return, .cur_pc, .mem_addr,
		.mem_wdata, .mem_we, .mem_re, .mem_rdata, .result, .result_we, .new_pc, .pc_load,
		.busy, .cond_flags, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

	always #2 mclk = ~mclk;
	// stack memory; idle read data inverts so stale bytes never look valid
	always @(posedge mclk) begin
		if (mem_we)
			mem[mem_addr[7:0]] <= mem_wdata;
		mem_rdata <= mem_re ? mem[mem_addr[7:0]] : ~mem_rdata;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			test_done;
		end
	end
	////////////////////////////////////////
	task test_done; begin
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end endtask
	task wr(input [3:0] a, input [7:0] d); begin
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge mclk) reg_wr <= 0;
		@(posedge mclk);
	end endtask
	task rd(input [3:0] a, input [7:0] e); begin
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge mclk) reg_rd <= 0;
		#1 `CHK(reg_rdata, e)
		@(posedge mclk);
	end endtask
	// expected answer; status flags not named by an op keep their value
	task mdl(input pf, input [7:0] oc, d, s); begin
		ew = 1;
		if (pf) begin
			er = d >> 1;
			ef[7] = d[0];
			ef[4] = d[7] ^ er[7];
		end else if (oc < 8'h30) begin
			er = d - s;
			ef[7] = d < s;
			ef[4] = (d[7] ^ s[7]) & (d[7] ^ er[7]);
			ef[3:2] = {1'b1, d[3:0] < s[3:0]};
		end else if (oc < 8'h80) begin
			er = oc[4] ? d & s : ~d & s;
			ew = 0;
			ef[4] = 0;
		end else if (oc < 8'hC0) begin
			er = d ^ s;
			ef[4] = 0;
		end else if (oc < 8'hE0) begin
			er = {d[7], d[7:1]};
			ef[7] = d[0];
			ef[4] = 0;
		end else
			er = {d[3:0], d[7:4]};
		ef[6:5] = {er == 8'h00, er[7]};
	end endtask
	task op(input pf, input [7:0] oc, d, s); begin
		op_prefix <= pf;
		opcode <= oc;
		dst_data <= d;
		src_data <= s;
		op_valid <= 1;
		@(posedge mclk) op_valid <= 0;
		#1 `CHK(result, er)
		`CHK(result_we, ew)
		`CHK(cond_flags, ef[7:4])
		@(posedge mclk);
	end endtask
	// count cycles up to the pc load and check the loaded value
	task wpl(input integer n, input [15:0] pc); begin
		i = 1;
		do begin
			@(posedge mclk) #1 i++;
		end while (pc_load !== 1'b1 && i < 20);
		`CHK(i, n)
		`CHK(new_pc, pc)
		@(posedge mclk);
	end endtask
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk);
		rst_b <= 1;
		@(posedge mclk);
		wr(0, 8'hFF);
		rd(0, 8'hFF);
		rst_b <= 0;
		@(posedge mclk) rst_b <= 1;
		@(posedge mclk);
		rd(0, 8'h03);
		wr(4'h9, 8'h55);
		rd(4'h9, 8'h00);
		ef = 8'h03;
		// every opcode of the slice, plain and prefixed, three operand pairs
		for (k = 0; k < 512; k++) begin
			p = k[8];
			c = k[7:0];
			if (p ? c[7:1] == 7'h60 : c[7:1] == 7'h68 || c[7:1] == 7'h78 ||
				hi_ok[c[7:4]] && c[3:0] > 4'h1 && c[3:0] < 4'hA)
				for (j = 0; j < 3; j++) begin
					mdl(p, c, dv[j], sv[j]);
					op(p, c, dv[j], sv[j]);
					rd(0, ef);
				end
		end
		// vector call, interrupt entry, illegal trap, each then returned from
		mem[8'h40] = 8'h56;
		mem[8'h41] = 8'h9A;
		for (k = 0; k < 3; k++) begin
			wr(1, 8'h01);
			wr(2, 8'h00);
			cur_pc <= 16'h1234;
			src_data <= 8'h40;
			op_prefix <= 0;
			opcode <= 8'hF2;
			op_valid <= k == 0;
			irq_entry <= k == 1;
			illegal_trap <= k == 2;
			@(posedge mclk) op_valid <= 0;
			irq_entry <= 0;
			illegal_trap <= 0;
			wpl(6, 16'h569A);
			`CHK(mem[8'hFE], 8'h12)
			`CHK(mem[8'hFF], 8'h34)
			`CHK(mem[8'hFD], ef)
			rd(2, 8'hFD);
			wr(0, 8'h00);
			interrupt_return <= 1;
			@(posedge mclk) interrupt_return <= 0;
			wpl(5, 16'h1234);
			rd(0, ef);
		end
		test_done;
	end
endmodule
